// ---- rtl/alst_pkg.sv ----
// Purpose: Constants for the channel 4 to 7 threshold alert flag register block.
// Assumes: APB slave with 32-bit data and 8-bit byte addresses.
// Notes:   All offsets, field positions, reset values and widths live here.
`default_nettype none

package alst_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int unsigned ALST_NUM_CH  = 4;
   localparam int unsigned ALST_DATA_W  = 16;
   localparam int unsigned ALST_FLAG_W  = 8;
   localparam int unsigned ALST_ADDR_W  = 8;
   localparam int unsigned ALST_CHAN_W  = 4;
   localparam int unsigned ALST_APB_W   = 32;

   // First converter channel served by this block.
   localparam logic [3:0]  ALST_CH_BASE = 4'h4;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   // The flag register keeps its printed index; its byte address is four times it.
   localparam logic [5:0]  ALST_FLAGS_INDEX     = 6'h16;
   localparam logic [7:0]  ALST_ADDR_FLAGS      = {ALST_FLAGS_INDEX, 2'b00};
   localparam logic [7:0]  ALST_ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ALST_ADDR_INT_STATUS = 8'h04;
   localparam logic [7:0]  ALST_ADDR_INT_MASK   = 8'h08;
   // Per-channel banks: base plus four times the local channel number.
   localparam logic [7:0]  ALST_ADDR_LOW_BASE   = 8'h10;
   localparam logic [7:0]  ALST_ADDR_HIGH_BASE  = 8'h20;
   localparam logic [7:0]  ALST_ADDR_BAND_BASE  = 8'h30;
   localparam logic [7:0]  ALST_BANK_MASK       = 8'hf0;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   localparam int unsigned ALST_CTRL_EN_LSB     = 0;
   localparam int unsigned ALST_CTRL_MODE_BIT   = 4;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]  ALST_FLAGS_RST       = 8'h00;
   localparam logic [7:0]  ALST_INT_RST         = 8'h00;
   localparam logic [7:0]  ALST_MASK_RST        = 8'h00;
   localparam logic [3:0]  ALST_EN_RST          = 4'h0;
   localparam logic        ALST_MODE_RST        = 1'b0;
   localparam logic [15:0] ALST_LOW_RST         = 16'h0000;
   localparam logic [15:0] ALST_HIGH_RST        = 16'hffff;
   localparam logic [15:0] ALST_BAND_RST        = 16'h0000;

endpackage

`default_nettype wire

// ---- rtl/alst_flags.sv ----
// Purpose: Sticky upper and lower threshold alert flags for channels 4 to 7,
//          with clear on read, optional hysteresis auto-clear and an APB slave.
// Assumes: Conversion results arrive on pclk from logic in the same domain;
//          ce stays high for the whole of any APB transfer.
// Notes:   Every output comes straight from a flip-flop; pready adds no wait state.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Channel 7 low flag bit7 on result<=low.
// R2: Channel 7 high flag bit6 on result>=high.
// R3: Channel 6 low bit5, high bit4.
// R4: Channel 5 low bit3, high bit2.
// R5: Channel 4 low bit1, high bit0.
// R6: Flags set only while detection enabled.
// R7: Reading clears flags; writes cannot set them.
// R8: Alert mode clears flag beyond hysteresis band.
// R9: Flag register at index 0x16, resets 0x00.
// R10: Read returns old value; concurrent set survives.
module alst_flags
   import alst_pkg::*;
(
   // Clock, reset and enable
   input  wire  logic                   pclk,
   input  wire  logic                   presetn,
   input  wire  logic                   ce,
   // APB slave
   input  wire  logic                   psel,
   input  wire  logic                   penable,
   input  wire  logic                   pwrite,
   input  wire  logic [ALST_ADDR_W-1:0] paddr,
   input  wire  logic [ALST_APB_W-1:0]  pwdata,
   output var   logic [ALST_APB_W-1:0]  prdata,
   output var   logic                   pready,
   output var   logic                   pslverr,
   // Conversion results
   input  wire  logic                   conv_valid,
   input  wire  logic [ALST_CHAN_W-1:0] conv_channel,
   input  wire  logic [ALST_DATA_W-1:0] conv_result,
   // Status outputs
   output var   logic [ALST_FLAG_W-1:0] alert_flags,
   output var   logic                   irq
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [ALST_NUM_CH-1:0] ctrl_en_reg;
   logic [ALST_NUM_CH-1:0] ctrl_en_next;
   logic                   alert_mode_reg;
   logic                   alert_mode_next;
   logic [ALST_FLAG_W-1:0] int_mask_reg;
   logic [ALST_FLAG_W-1:0] int_mask_next;
   logic [ALST_DATA_W-1:0] low_thr_reg  [ALST_NUM_CH];
   logic [ALST_DATA_W-1:0] low_thr_next [ALST_NUM_CH];
   logic [ALST_DATA_W-1:0] high_thr_reg [ALST_NUM_CH];
   logic [ALST_DATA_W-1:0] high_thr_next[ALST_NUM_CH];
   logic [ALST_DATA_W-1:0] band_reg     [ALST_NUM_CH];
   logic [ALST_DATA_W-1:0] band_next    [ALST_NUM_CH];

   logic [ALST_FLAG_W-1:0] flags_reg;
   logic [ALST_FLAG_W-1:0] flags_next;
   logic [ALST_FLAG_W-1:0] int_status_reg;
   logic [ALST_FLAG_W-1:0] int_status_next;
   logic                   irq_reg;
   logic                   irq_next;

   logic [ALST_APB_W-1:0]  prdata_reg;
   logic [ALST_APB_W-1:0]  prdata_next;
   logic                   pready_reg;
   logic                   pready_next;
   logic                   pslverr_reg;
   logic                   pslverr_next;

   logic                   apb_setup;
   logic                   apb_done;
   logic                   apb_wr;
   logic                   apb_rd_flags;
   logic                   hit_ctrl;
   logic                   hit_status;
   logic                   hit_mask;
   logic                   hit_flags;
   logic                   hit_low;
   logic                   hit_high;
   logic                   hit_band;
   logic                   mapped;
   logic [1:0]             bank_ch;
   logic                   word_aligned;

   logic [ALST_FLAG_W-1:0] set_vec;
   logic [ALST_FLAG_W-1:0] auto_clr_vec;
   logic [ALST_FLAG_W-1:0] read_clr_vec;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   // The words are control, interrupt status and interrupt mask, then three
   // banks of four per-channel words for low thresholds, high thresholds and
   // bands, channel 4 first, and the flag word at four times its index.
   // Any other address, or one that is not word aligned, answers with pslverr;
   // a write there is dropped and a read returns zero.
   assign apb_setup    = psel & ~penable;
   assign apb_done     = psel & penable & pready_reg;
   assign apb_wr       = apb_done & pwrite;
   assign bank_ch      = paddr[3:2];
   assign word_aligned = (paddr[1:0] == 2'h0);
   assign hit_ctrl     = (paddr == ALST_ADDR_CTRL);
   assign hit_status   = (paddr == ALST_ADDR_INT_STATUS);
   assign hit_mask     = (paddr == ALST_ADDR_INT_MASK);
   assign hit_flags    = (paddr == ALST_ADDR_FLAGS);                    // [R9]
   assign hit_low      = ((paddr & ALST_BANK_MASK) == ALST_ADDR_LOW_BASE) && word_aligned;
   assign hit_high     = ((paddr & ALST_BANK_MASK) == ALST_ADDR_HIGH_BASE) && word_aligned;
   assign hit_band     = ((paddr & ALST_BANK_MASK) == ALST_ADDR_BAND_BASE) && word_aligned;
   assign mapped       = hit_ctrl | hit_status | hit_mask | hit_flags
                         | hit_low | hit_high | hit_band;
   assign apb_rd_flags = apb_done & ~pwrite & hit_flags;

   // ------------------------------------------------------------------
   // Per-channel threshold comparison
   // ------------------------------------------------------------------
   for (genvar k = 0; k < ALST_NUM_CH; k++) begin : g_ch
      logic             hit;
      logic [16:0]      res_ext;
      logic [16:0]      low_plus_band;
      logic [16:0]      res_plus_band;

      assign hit           = conv_valid && (conv_channel == ALST_CH_BASE + 4'(k));
      // Sums are one bit wider so that a threshold near full scale cannot wrap.
      assign res_ext       = {1'b0, conv_result};
      assign low_plus_band = {1'b0, low_thr_reg[k]} + {1'b0, band_reg[k]};
      assign res_plus_band = res_ext + {1'b0, band_reg[k]};

      // Lower flag sits one bit above the upper flag of the same channel.
      assign set_vec[2*k+1] = hit && ctrl_en_reg[k]
                              && (conv_result <= low_thr_reg[k]);       // [R1] [R3] [R4] [R5] [R6]
      assign set_vec[2*k]   = hit && ctrl_en_reg[k]
                              && (conv_result >= high_thr_reg[k]);      // [R2] [R3] [R4] [R5] [R6]

      // A result that has moved a full band back inside the window clears.
      assign auto_clr_vec[2*k+1] = hit && alert_mode_reg
                                   && (res_ext >= low_plus_band);       // [R8]
      assign auto_clr_vec[2*k]   = hit && alert_mode_reg
                                   && (res_plus_band <= {1'b0, high_thr_reg[k]}); // [R8]
   end

   // ------------------------------------------------------------------
   // Flag state
   // ------------------------------------------------------------------
   // Only the bits actually returned by the read are cleared, so a flag that
   // rises after the read data was captured is not lost.
   assign read_clr_vec = apb_rd_flags ? prdata_reg[ALST_FLAG_W-1:0] : ALST_FLAGS_RST; // [R10]

   // A set in the same cycle as any clear wins, so no conversion goes unseen.
   always_comb begin
      flags_next = (flags_reg & ~(read_clr_vec | auto_clr_vec)) | set_vec; // [R7] [R8] [R10]
   end

   // A low ce freezes the flags, a read clear included, which is why ce must
   // stay high across a whole transfer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= ALST_FLAGS_RST;                                     // [R9]
      end else if (ce) begin
         flags_reg <= flags_next;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt state
   // ------------------------------------------------------------------
   // Status bits reach irq in the cycle they are set; a mask write takes one
   // cycle longer because the mask is read from its register.
   always_comb begin
      int_status_next = int_status_reg;
      if (apb_wr && hit_status) begin
         int_status_next = int_status_reg & ~pwdata[ALST_FLAG_W-1:0];
      end
      int_status_next = int_status_next | set_vec;
      irq_next        = |(int_status_next & int_mask_reg);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= ALST_INT_RST;
         irq_reg        <= 1'b0;
      end else if (ce) begin
         int_status_reg <= int_status_next;
         irq_reg        <= irq_next;
      end
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   // The flag register has no write path; a write there is accepted and dropped.
   always_comb begin
      ctrl_en_next    = ctrl_en_reg;
      alert_mode_next = alert_mode_reg;
      int_mask_next   = int_mask_reg;
      low_thr_next    = low_thr_reg;
      high_thr_next   = high_thr_reg;
      band_next       = band_reg;
      if (apb_wr) begin                                                 // [R7]
         if (hit_ctrl) begin
            ctrl_en_next    = pwdata[ALST_CTRL_EN_LSB +: ALST_NUM_CH];
            alert_mode_next = pwdata[ALST_CTRL_MODE_BIT];
         end
         if (hit_mask) begin
            int_mask_next = pwdata[ALST_FLAG_W-1:0];
         end
         if (hit_low) begin
            low_thr_next[bank_ch] = pwdata[ALST_DATA_W-1:0];
         end
         if (hit_high) begin
            high_thr_next[bank_ch] = pwdata[ALST_DATA_W-1:0];
         end
         if (hit_band) begin
            band_next[bank_ch] = pwdata[ALST_DATA_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_reg    <= ALST_EN_RST;
         alert_mode_reg <= ALST_MODE_RST;
         int_mask_reg   <= ALST_MASK_RST;
         for (int i = 0; i < ALST_NUM_CH; i++) begin
            low_thr_reg[i]  <= ALST_LOW_RST;
            high_thr_reg[i] <= ALST_HIGH_RST;
            band_reg[i]     <= ALST_BAND_RST;
         end
      end else if (ce) begin
         ctrl_en_reg    <= ctrl_en_next;
         alert_mode_reg <= alert_mode_next;
         int_mask_reg   <= int_mask_next;
         low_thr_reg    <= low_thr_next;
         high_thr_reg   <= high_thr_next;
         band_reg       <= band_next;
      end
   end

   // ------------------------------------------------------------------
   // APB response
   // ------------------------------------------------------------------
   // Read data is captured at the end of the setup cycle and held through the
   // single access cycle, so the flag value returned is the pre-clear one.
   always_comb begin
      prdata_next  = prdata_reg;
      pready_next  = apb_setup;
      pslverr_next = apb_setup & ~mapped;
      if (apb_setup && !pwrite) begin
         prdata_next = '0;
         if (hit_ctrl) begin
            prdata_next[ALST_CTRL_EN_LSB +: ALST_NUM_CH] = ctrl_en_reg;
            prdata_next[ALST_CTRL_MODE_BIT]              = alert_mode_reg;
         end
         if (hit_status) begin
            prdata_next[ALST_FLAG_W-1:0] = int_status_reg;
         end
         if (hit_mask) begin
            prdata_next[ALST_FLAG_W-1:0] = int_mask_reg;
         end
         if (hit_flags) begin
            prdata_next[ALST_FLAG_W-1:0] = flags_reg;                   // [R10]
         end
         if (hit_low) begin
            prdata_next[ALST_DATA_W-1:0] = low_thr_reg[bank_ch];
         end
         if (hit_high) begin
            prdata_next[ALST_DATA_W-1:0] = high_thr_reg[bank_ch];
         end
         if (hit_band) begin
            prdata_next[ALST_DATA_W-1:0] = band_reg[bank_ch];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= '0;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else if (ce) begin
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign alert_flags = flags_reg;
   assign irq         = irq_reg;

endmodule // alst_flags

`default_nettype wire

// ---- bench/alst_flags_monitor.sv ----
// Purpose: Port-level checks of the channel 4 to 7 alert flag block.
// Assumes: One pclk domain; presetn low returns all state to its reset values.
// Notes:   Bound into alst_flags after the endmodule.
`timescale 1ns/1ps
`default_nettype none
module alst_flags_monitor
   import alst_pkg::*;
(
   // Clock, reset and enable
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   ce,
   // APB slave
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [ALST_ADDR_W-1:0] paddr,
   input wire logic [ALST_APB_W-1:0]  pwdata,
   input wire logic [ALST_APB_W-1:0]  prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // Conversions and status
   input wire logic                   conv_valid,
   input wire logic [ALST_CHAN_W-1:0] conv_channel,
   input wire logic [ALST_DATA_W-1:0] conv_result,
   input wire logic [ALST_FLAG_W-1:0] alert_flags,
   input wire logic                   irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       setup, rd_done, conv_here;
   logic [2:0] pair_lsb;
   assign conv_here = conv_valid && ce && conv_channel >= 4'h4 && conv_channel <= 4'h7;
   assign pair_lsb = {conv_channel[1:0], 1'h0};
   assign setup = psel && !penable && ce;
   assign rd_done = psel && penable && pready && !pwrite && paddr == ALST_ADDR_FLAGS;
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
   a_ready_after_setup: assert property (setup |=> pready) else $error("pready late");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_flags_mapped: assert property (
      setup && paddr == ALST_ADDR_FLAGS |=> !pslverr) else $error("flag address refused");
   a_set_needs_conv: assert property (
      (alert_flags & ~$past(alert_flags)) != 8'h00 |->
      $past(conv_here))
      else $error("flag set without conversion");
   a_set_right_pair: assert property (
      conv_valid && ce |=> ((alert_flags & ~$past(alert_flags)) &
      ~(8'h03 << $past(pair_lsb))) == 8'h00) else $error("wrong flag bits");
   a_flags_hold: assert property (
      !(conv_valid && ce) && !rd_done |=> $stable(alert_flags)) else $error("flags moved");
   a_read_clears: assert property (
      rd_done && !conv_valid |=> ({24'h0, alert_flags} & $past(prdata)) == 32'h0)
      else $error("read left flags set");
   a_read_value: assert property (
      setup && !pwrite && paddr == ALST_ADDR_FLAGS |=> prdata == {24'h0, $past(alert_flags)})
      else $error("read data wrong");
   c_read_nonzero: cover property (rd_done && prdata != 32'h0);
   c_conv: cover property (conv_valid && ce);
   c_error: cover property (pslverr);
   c_irq: cover property (irq);
endmodule // alst_flags_monitor
bind alst_flags alst_flags_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
   .conv_channel(conv_channel), .conv_result(conv_result), .alert_flags(alert_flags),
   .irq(irq));
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Directed APB and conversion tests of the alert flag block.
// Assumes: Thresholds 0x1000 low and 0x8000 high on every channel.
// Notes:   Expected values come from the bit layout, never from the design.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import alst_pkg::*;
;
   logic                   pclk, presetn, ce, psel, penable, pwrite, e;
   logic                   conv_valid, pready, pslverr, irq;
   logic [ALST_ADDR_W-1:0] paddr;
   logic [ALST_APB_W-1:0]  pwdata, prdata, q;
   logic [ALST_CHAN_W-1:0] conv_channel;
   logic [ALST_DATA_W-1:0] conv_result;
   logic [ALST_FLAG_W-1:0] alert_flags;
   int                     n_errors, n_checks;
   alst_flags uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
      .conv_channel(conv_channel), .conv_result(conv_result),
      .alert_flags(alert_flags), .irq(irq));
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   task automatic report_and_stop;
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data and error are taken only at the edge that sees pready high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic conv(input logic [3:0] ch, input logic [15:0] r);
      @(posedge pclk);
      conv_valid <= 1'h1;
      conv_channel <= ch;
      conv_result <= r;
      @(posedge pclk);
      conv_valid <= 1'h0;
      conv_result <= ~r;
   endtask
   task automatic chk_irq(input logic exp);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask
   initial begin
      {presetn, psel, penable, pwrite, conv_valid, n_errors, n_checks} = '0;
      {paddr, pwdata, conv_channel, conv_result} = '0;
      ce = 1'h1;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      rd(ALST_ADDR_FLAGS, 32'h0);
      rd(ALST_ADDR_HIGH_BASE, 32'hffff);
      apb(1'h0, 8'hfc, 32'h0);
      chk({q[30:0], e}, 32'h1);
      apb(1'h1, ALST_ADDR_INT_MASK, 32'hff);
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, ALST_ADDR_LOW_BASE + 8'(4 * i), 32'h1000);
         apb(1'h1, ALST_ADDR_HIGH_BASE + 8'(4 * i), 32'h8000);
      end
      apb(1'h1, ALST_ADDR_CTRL, 32'hf);
      for (int i = 0; i < 4; i++) begin
         conv(4'(4 + i), 16'h1001);
         conv(4'(4 + i), 16'h7fff);
         rd(ALST_ADDR_FLAGS, 32'h0);
         conv(4'(4 + i), 16'h1000);
         rd(ALST_ADDR_FLAGS, 32'h2 << (2 * i));
         conv(4'(4 + i), 16'h8000);
         rd(ALST_ADDR_FLAGS, 32'h1 << (2 * i));
      end
      conv(4'h3, 16'h0000);
      rd(ALST_ADDR_FLAGS, 32'h0);
      chk_irq(1'h1);
      apb(1'h1, ALST_ADDR_INT_STATUS, 32'hff);
      chk_irq(1'h0);
      apb(1'h1, ALST_ADDR_CTRL, 32'h7);
      conv(4'h7, 16'h0000);
      apb(1'h1, ALST_ADDR_FLAGS, 32'hff);
      rd(ALST_ADDR_FLAGS, 32'h0);
      apb(1'h1, ALST_ADDR_BAND_BASE, 32'h100);
      apb(1'h1, ALST_ADDR_CTRL, 32'h1f);
      conv(4'h4, 16'h0f00);
      conv(4'h4, 16'h10ff);
      @(posedge pclk);
      chk({24'h0, alert_flags}, 32'h2);
      conv(4'h4, 16'h1100);
      @(posedge pclk);
      chk({24'h0, alert_flags}, 32'h0);
      chk_irq(1'h1);
      apb(1'h1, ALST_ADDR_INT_MASK, 32'h0);
      chk_irq(1'h0);
      // A flag raised at the setup edge is missing from the read data and must survive.
      fork
         apb(1'h0, ALST_ADDR_FLAGS, 32'h0);
         conv(4'h7, 16'h0000);
      join
      chk(q, 32'h0);
      rd(ALST_ADDR_FLAGS, 32'h80);
      // With ce low a conversion that would set a flag must leave no trace.
      @(posedge pclk);
      ce <= 1'h0;
      conv(4'h4, 16'h0f00);
      ce <= 1'h1;
      @(posedge pclk);
      chk({24'h0, alert_flags}, 32'h0);
      report_and_stop();
   end
   initial begin
      #1000000;
      n_errors++;
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
